// File: shared/dma_seq_pkg.sv
// shared constants and types for the dma channel block sequencer
// assumes a single clock domain and a simple strobe register port
package dma_seq_pkg;
    // register offsets (byte addresses, one 16-bit register every 4 bytes)
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_REQUEST   = 8'h04;
    localparam logic [7:0] OFF_START_A   = 8'h08;
    localparam logic [7:0] OFF_START_B   = 8'h0c;
    localparam logic [7:0] OFF_PERIPH    = 8'h10;
    localparam logic [7:0] OFF_COUNT     = 8'h14;
    localparam logic [7:0] OFF_COLLISION = 8'h18;
    localparam logic [7:0] OFF_STATUS    = 8'h1c;
    // control field positions
    localparam int CTL_ENABLE = 15;
    localparam int CTL_SIZE   = 14;
    localparam int CTL_DIR    = 13;
    localparam int CTL_HALF   = 12;
    localparam int CTL_NULL_WRITE_ENABLE  = 11;
    localparam int CTL_ADDRESSING_MODE  = 4;
    localparam int CTL_MODE   = 0;
    localparam int REQ_FORCE  = 15;
    localparam logic [15:0] CTL_MASK   = 16'hf833;
    localparam logic [15:0] REQ_MASK   = 16'h007f;
    localparam logic [9:0]  COUNT_MASK = 10'h3ff;
    localparam logic [15:0] RESET_VAL  = 16'h0000;
    localparam logic [1:0]  AM_POSTINC = 2'h0;
    localparam logic [1:0]  AM_CONST   = 2'h1;
    localparam logic [1:0]  AM_PERIND  = 2'h2;
    localparam logic [3:0]  TRAP_LEVEL = 4'ha;

    typedef enum logic [1:0] {IDLE, XFER, NULLWR} phase_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } regbus_t;

    typedef struct packed {
        logic [15:0] ramAddr;
        logic        ramWr;
        logic        ramRd;
        logic [15:0] perAddr;
        logic        perWr;
        logic        perRd;
        logic        perNull;
    } xfer_t;

    typedef struct packed {
        logic [15:0] control;
        logic [15:0] request;
        logic [15:0] startA;
        logic [15:0] startB;
        logic [15:0] periph;
        logic [9:0]  count;
        logic [15:0] ramAddr;
        logic [9:0]  done;
        logic        pong;
        logic        forcePend;
        logic        reqPend;
        logic        irq;
        logic        ramCol;
        logic        perCol;
        phase_t      phase;
        logic [15:0] rdata;
        xfer_t       xfer;
    } state_t;
endpackage : dma_seq_pkg

// File: design/dma_channel_block_sequencer.sv
// one dma channel: registers, block sequencing, force, collisions
// assumes ram/peripheral data paths are outside; this block issues addresses
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
// What this block does
// R1 - null-write set, direction clear: each peripheral read also writes null data
// R2 - mode bit 0 clear: continuous, channel rearms itself at buffer end
// R3 - continuous last transfer: next ram address is the selected start address
// R4 - continuous block end: flag set if half clear; channel stays enabled
// R5 - mode bit 0 set: one-shot, channel disables itself at buffer end
// R6 - one-shot last transfer leaves ram address at last accessed location
// R7 - one-shot block end: flag set if half clear; channel always disables
// R8 - mode bit 1 set: alternate primary and secondary start addresses
// R9 - force bit on enabled channel moves exactly one element
// R10 - force bit cleared by hardware on completion, software cannot clear it
// R11 - setting force while a request is being serviced is ignored
// R12 - after a forced transfer, hardware requests trigger again
// R13 - request field bits 6:0 pick one of 128 request lines
// R14 - interrupt on full block (half clear) or half block (half set)
// R15 - channel drives its own interrupt request output
// R16 - interrupts come only from completed transfers, not peripheral errors
// R17 - cpu and channel writing same ram address same cycle is a collision
// R18 - cpu and channel writing same peripheral register is a collision
// R19 - all collisions merge into one non-maskable trap, level 10
// R20 - separate ram and peripheral collision flags kept per channel
// R21 - peripheral buffering must be disabled by software before use
// R22 - direction set: ram to peripheral; clear: peripheral to ram
// R23 - post-increment adds 2 per word, 1 per byte
// R24 - addressing mode 00 increment, 01 constant, 10 peripheral offset ored
// R25 - buffer end when elements moved reaches count plus one
// R26 - half mode raises flag when elements reach half of block length
module dma_channel_block_sequencer (
    input  wire logic                ref_clk,     // system clock
    input  wire logic                rst,         // sync reset, high
    input  wire dma_seq_pkg::regbus_t bus,        // register port
    output logic [15:0]              rdata,       // read data, next cycle
    input  wire logic [127:0]        irqLines,    // request sources
    input  wire logic [15:0]         perOffset,   // peripheral indirect offset
    input  wire logic                cpuRamWr,    // cpu ram write strobe
    input  wire logic [15:0]         cpuRamAddr,  // cpu ram write address
    input  wire logic                cpuPerWr,    // cpu peripheral write
    input  wire logic [15:0]         cpuPerAddr,  // cpu peripheral address
    output dma_seq_pkg::xfer_t       xfer,        // transfer strobes/address
    output logic                     chanIrq,     // channel interrupt pulse
    output logic                     trap,        // collision trap level
    output logic [3:0]               trapLevel    // trap priority
);
    import dma_seq_pkg::*;

    state_t s_q;
    state_t s_d;

    // =========================================================
    // helpers
    // =========================================================
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    logic        en;
    logic        byteMode;
    logic        dirOut;
    logic        half;
    logic        oneShot;
    logic        pingPong;
    logic [1:0]  addressing_mode;
    logic [15:0] selStart;
    logic [15:0] effAddr;
    logic [15:0] step;
    logic [9:0]  doneNext;
    logic        lastXfer;
    logic        halfHit;
    logic        hwReq;
    logic        startXfer;

    always_comb begin
        en       = s_q.control[CTL_ENABLE];
        byteMode = s_q.control[CTL_SIZE];
        dirOut   = s_q.control[CTL_DIR];                  // R22
        half     = s_q.control[CTL_HALF];
        oneShot  = s_q.control[CTL_MODE];                 // R2 R5
        pingPong = s_q.control[CTL_MODE+1];               // R8
        addressing_mode    = s_q.control[CTL_ADDRESSING_MODE+:2];
        selStart = s_q.pong ? s_q.startB : s_q.startA;    // R8
        step     = byteMode ? 16'h0001 : 16'h0002;        // R23
        effAddr  = (addressing_mode == AM_PERIND) ?
                   (selStart | perOffset) : s_q.ramAddr;    // R24
        if (!byteMode) begin
            effAddr[0] = 1'b0;
        end
        doneNext = s_q.done + 10'h001;
        lastXfer = (s_q.done == s_q.count);               // R25
        halfHit  = (doneNext == ({1'b0, s_q.count[9:1]} + 10'h001)); // R26
        hwReq    = irqLines[s_q.request[6:0]];            // R13
        startXfer = en && (s_q.reqPend || s_q.forcePend);
    end

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        s_d = s_q;
        s_d.irq   = 1'b0;
        s_d.rdata = 16'h0000;
        s_d.xfer  = '0;
        // latch a hardware request; forced ones latch at the request write
        if (en && hwReq && s_q.phase == IDLE) begin
            s_d.reqPend = 1'b1;                           // R12
        end

        unique case (s_q.phase)
            IDLE: begin
                if (startXfer) begin
                    s_d.phase = XFER;
                end
            end
            XFER: begin
                s_d.xfer.ramAddr = effAddr;
                s_d.xfer.perAddr = s_q.periph;
                s_d.xfer.ramRd   = dirOut;                // R22
                s_d.xfer.perWr   = dirOut;
                s_d.xfer.perRd   = !dirOut;
                s_d.xfer.ramWr   = !dirOut;
                s_d.reqPend   = 1'b0;
                s_d.forcePend = 1'b0;                     // R9 R10
                s_d.request[REQ_FORCE] = 1'b0;            // R10
                s_d.done = doneNext;
                if (half && halfHit) begin
                    s_d.irq = 1'b1;                       // R14 R16 R26
                end
                if (lastXfer) begin
                    s_d.done = 10'h000;
                    if (!half) begin
                        s_d.irq = 1'b1;                   // R4 R7 R14
                    end
                    if (oneShot) begin
                        s_d.control[CTL_ENABLE] = 1'b0;   // R5 R7
                    end else begin
                        // R2 R3: rearm from the start register of the next buffer
                        s_d.ramAddr = (pingPong && !s_q.pong) ?
                                      s_q.startB : s_q.startA;
                    end
                    if (pingPong) begin
                        s_d.pong = !s_q.pong;             // R8
                    end
                end else if (addressing_mode == AM_POSTINC) begin
                    s_d.ramAddr = s_q.ramAddr + step;     // R23 R6
                end
                // R1: null write rides behind a receive
                s_d.phase = (s_q.control[CTL_NULL_WRITE_ENABLE] && !dirOut) ?
                            NULLWR : IDLE;
            end
            NULLWR: begin
                s_d.xfer.perAddr = s_q.periph;
                s_d.xfer.perWr   = 1'b1;                  // R1
                s_d.xfer.perNull = 1'b1;
                s_d.phase        = IDLE;
            end
            default: begin
                s_d.phase = IDLE;
            end
        endcase

        // collisions: set wins, cleared by writing zero bits
        if (bus.wr && hit(bus.addr, OFF_COLLISION)) begin
            s_d.ramCol = s_q.ramCol & bus.wdata[0];
            s_d.perCol = s_q.perCol & bus.wdata[1];
        end
        if (s_d.xfer.ramWr && cpuRamWr &&
            cpuRamAddr == s_d.xfer.ramAddr) begin
            s_d.ramCol = 1'b1;                            // R17 R20
        end
        if (s_d.xfer.perWr && cpuPerWr &&
            cpuPerAddr == s_d.xfer.perAddr) begin
            s_d.perCol = 1'b1;                            // R18 R20
        end

        // register writes
        if (bus.wr) begin
            if (hit(bus.addr, OFF_CONTROL)) begin
                s_d.control = bus.wdata & CTL_MASK;
                if (!s_q.control[CTL_ENABLE] &&
                    bus.wdata[CTL_ENABLE]) begin
                    s_d.ramAddr = s_q.startA;
                    s_d.pong    = 1'b0;
                    s_d.done    = 10'h000;
                end
            end
            if (hit(bus.addr, OFF_REQUEST)) begin
                s_d.request[6:0] = bus.wdata[6:0];        // R13
                // R11: no effect while a request is underway
                if (bus.wdata[REQ_FORCE] && s_q.phase == IDLE &&
                    !s_q.reqPend && !s_q.forcePend) begin
                    s_d.request[REQ_FORCE] = 1'b1;        // R9
                    s_d.forcePend = 1'b1;
                end
            end
            if (hit(bus.addr, OFF_START_A)) begin
                s_d.startA = bus.wdata;
            end
            if (hit(bus.addr, OFF_START_B)) begin
                s_d.startB = bus.wdata;
            end
            if (hit(bus.addr, OFF_PERIPH)) begin
                s_d.periph = bus.wdata;
            end
            if (hit(bus.addr, OFF_COUNT)) begin
                s_d.count = bus.wdata[9:0] & COUNT_MASK;
            end
        end

        // register reads; start registers read back the live pointer
        if (bus.rd) begin
            if (hit(bus.addr, OFF_CONTROL)) begin
                s_d.rdata = s_q.control;
            end else if (hit(bus.addr, OFF_REQUEST)) begin
                s_d.rdata = s_q.request;
            end else if (hit(bus.addr, OFF_START_A) ||
                         hit(bus.addr, OFF_START_B)) begin
                s_d.rdata = s_q.ramAddr;
            end else if (hit(bus.addr, OFF_PERIPH)) begin
                s_d.rdata = s_q.periph;
            end else if (hit(bus.addr, OFF_COUNT)) begin
                s_d.rdata = {6'h00, s_q.count};
            end else if (hit(bus.addr, OFF_COLLISION)) begin
                s_d.rdata = {14'h0000, s_q.perCol, s_q.ramCol};
            end else if (hit(bus.addr, OFF_STATUS)) begin
                s_d.rdata = {s_q.pong, 5'h00, s_q.done};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    assign rdata     = s_q.rdata;
    assign xfer      = s_q.xfer;
    assign chanIrq   = s_q.irq;                           // R15
    assign trap      = s_q.ramCol | s_q.perCol;           // R19
    assign trapLevel = TRAP_LEVEL;                        // R19

    // =========================================================
    // assertions
    // =========================================================
    a_oneshot_disable: assert property ( // R5
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && lastXfer && oneShot && !bus.wr)
        |=> !s_q.control[CTL_ENABLE])
        else $error("one-shot channel stayed enabled");
    a_cont_rearm: assert property ( // R3
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && lastXfer && !oneShot && !pingPong && !bus.wr)
        |=> s_q.ramAddr == $past(s_q.startA))
        else $error("continuous channel did not reload start");

    a_oneshot_hold: assert property ( // R6
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && lastXfer && oneShot && !bus.wr)
        |=> $stable(s_q.ramAddr))
        else $error("one-shot last transfer moved address");
    a_full_irq: assert property ( // R4
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && lastXfer && !half) |=> chanIrq)
        else $error("block end raised no interrupt");

    a_irq_cause: assert property ( // R16
        @(posedge ref_clk) disable iff (rst)
        chanIrq |-> $past(s_q.phase) == XFER)
        else $error("interrupt without a transfer");
    a_null_follow: assert property ( // R1
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && s_q.control[CTL_NULL_WRITE_ENABLE] && !dirOut)
        |=> ##1 (xfer.perWr && xfer.perNull))
        else $error("null write missing");

    a_incr_step: assert property ( // R23
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && !lastXfer && addressing_mode == AM_POSTINC && !bus.wr)
        |=> s_q.ramAddr == $past(s_q.ramAddr) + $past(step))
        else $error("post-increment step wrong");
    a_force_clear: assert property ( // R10
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER) |=> !s_q.request[REQ_FORCE])
        else $error("force bit not cleared");

    a_ram_collide: assert property ( // R17
        @(posedge ref_clk) disable iff (rst)
        (s_d.xfer.ramWr && cpuRamWr && cpuRamAddr == s_d.xfer.ramAddr)
        |=> trap ##1 trap)
        else $error("ram collision did not trap");
    a_per_collide: assert property ( // R18
        @(posedge ref_clk) disable iff (rst)
        (s_d.xfer.perWr && cpuPerWr && cpuPerAddr == s_d.xfer.perAddr)
        |=> trap)
        else $error("peripheral collision did not trap");

    a_force_ignore: assert property ( // R11
        @(posedge ref_clk) disable iff (rst)
        (bus.wr && hit(bus.addr, OFF_REQUEST) && bus.wdata[REQ_FORCE] &&
         s_q.phase != IDLE) |=> !s_q.forcePend)
        else $error("force accepted while busy");
    a_half_irq: assert property ( // R26
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && half && halfHit) |=> chanIrq)
        else $error("half block raised no interrupt");

    a_half_quiet: assert property ( // R4
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && lastXfer && half && !halfHit)
        |=> !chanIrq)
        else $error("half mode interrupted at block end");
    a_cont_enable: assert property ( // R2
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && en && lastXfer && !oneShot && !bus.wr)
        |=> s_q.control[CTL_ENABLE])
        else $error("continuous channel disabled itself");

    a_pong_flip: assert property ( // R8
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && lastXfer && pingPong && !bus.wr)
        |=> s_q.pong != $past(s_q.pong))
        else $error("ping-pong buffer did not switch");
    a_const_addr: assert property ( // R24
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && !lastXfer && addressing_mode == AM_CONST && !bus.wr)
        |=> $stable(s_q.ramAddr))
        else $error("constant address moved");

    a_null_path: assert property ( // R1
        @(posedge ref_clk) disable iff (rst)
        xfer.perNull |-> (xfer.perWr && !xfer.ramWr && !xfer.ramRd))
        else $error("null write on wrong path");
    a_dir_write: assert property ( // R22
        @(posedge ref_clk) disable iff (rst)
        xfer.ramWr |-> (xfer.perRd && !xfer.perWr))
        else $error("receive drove the peripheral");

    a_word_align: assert property ( // R23
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && !byteMode) |=> !xfer.ramAddr[0])
        else $error("word transfer on odd address");
    a_block_wrap: assert property ( // R25
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == XFER && lastXfer) |=> s_q.done == 10'h000)
        else $error("element count not restarted");

    a_hold_disabled: assert property ( // R9
        @(posedge ref_clk) disable iff (rst)
        (s_q.phase == IDLE && !en) |=> s_q.phase == IDLE)
        else $error("disabled channel started a transfer");

    c_block_end: cover property (@(posedge ref_clk) disable iff (rst)
        s_q.phase == XFER && lastXfer);
    c_forced: cover property (@(posedge ref_clk) disable iff (rst)
        s_q.forcePend ##1 s_q.phase == XFER);
    c_half_irq: cover property (@(posedge ref_clk) disable iff (rst)
        chanIrq && half);
    c_null_write: cover property (@(posedge ref_clk) disable iff (rst)
        xfer.perNull);
    c_trap: cover property (@(posedge ref_clk) disable iff (rst) $rose(trap));
endmodule : dma_channel_block_sequencer

// File: testbench/dma_far_side_model.sv
// far-side model: peripherals raising one request line per element
// assumes the channel pulses ramWr or ramRd once for each element moved
`timescale 1ns/1ns
module dma_far_side_model (
    input  wire logic               ref_clk,  // system clock
    input  wire logic               rst,      // sync reset, high
    input  wire logic [6:0]         srcSel,   // line to raise
    input  wire logic [7:0]         burst,    // requests to make
    input  wire logic               go,       // start a burst
    input  wire dma_seq_pkg::xfer_t xfer,     // channel strobes
    output logic [127:0]            irqLines  // request lines
);
    import dma_seq_pkg::*;
    logic [7:0] leftQ;
    logic       waitQ;
    logic [1:0] gapQ;
    // ==========================================================
    // request pacing
    // no next pulse before the element moved: the peripheral keeps
    // no multi-word buffer, so an early request would be lost data
    always_ff @(posedge ref_clk) begin
        irqLines <= '0;
        if (rst || go) begin
            leftQ <= rst ? 8'h00 : burst;
            waitQ <= 1'b0;
            gapQ  <= 2'h0;
        end else if (waitQ) begin
            waitQ <= ~(xfer.ramWr | xfer.ramRd);
            gapQ  <= 2'h3;
        end else if (gapQ != 2'h0) begin
            gapQ <= gapQ - 2'h1;
        end else if (leftQ != 8'h00) begin
            irqLines[srcSel] <= 1'b1;
            leftQ <= leftQ - 8'h01;
            waitQ <= 1'b1;
        end
    end
endmodule : dma_far_side_model

// File: testbench/tb_top.sv
// self-checking bench for the dma channel block sequencer
// assumes the far-side model paces requests on the selected line
`timescale 1ns/1ns
module tb_top;
    import dma_seq_pkg::*;
    logic         ref_clk;
    logic         rst;
    regbus_t      bus;
    logic [15:0]  rdata;
    logic [127:0] irqLines;
    logic         cpuRamWr;
    logic [15:0]  cpuRamAddr;
    logic         cpuPerWr;
    logic [15:0]  cpuPerAddr;
    xfer_t        xfer;
    logic         chanIrq;
    logic         trap;
    logic [3:0]   trapLevel;
    logic [6:0]   srcSel;
    logic [7:0]   burst;
    logic         go;
    logic [17:0]  addrQ[$];
    logic [17:0]  perSeen;
    logic [15:0]  perOffset;
    logic [15:0]  rv;
    int           irqCnt;
    int           nullCnt;
    int           bad_count;
    int           check_count;

    dma_channel_block_sequencer dut_u (.ref_clk(ref_clk), .rst(rst),
        .bus(bus), .rdata(rdata), .irqLines(irqLines),
        .perOffset(perOffset), .cpuRamWr(cpuRamWr), .cpuRamAddr(cpuRamAddr),
        .cpuPerWr(cpuPerWr), .cpuPerAddr(cpuPerAddr), .xfer(xfer),
        .chanIrq(chanIrq), .trap(trap), .trapLevel(trapLevel));
    dma_far_side_model partner_u (.ref_clk(ref_clk), .rst(rst),
        .srcSel(srcSel), .burst(burst), .go(go), .xfer(xfer),
        .irqLines(irqLines));

    // ==========================================================
    // monitor: direction bits beside the ram address of each element
    always @(posedge ref_clk) begin
        if (xfer.ramWr | xfer.ramRd)
            addrQ.push_back({xfer.ramWr, xfer.perWr, xfer.ramAddr});
        if (xfer.perNull)
            nullCnt++;
        if ((xfer.perWr | xfer.perRd) && !xfer.perNull)
            perSeen = {xfer.perRd, xfer.perWr, xfer.perAddr};
        if (chanIrq)
            irqCnt++;
    end

    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [15:0] exp,
                      input string what);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1 check(what, rdata, exp);
    endtask : rc
    // at least 40 cycles, so a stray extra transfer still lands
    task automatic run(input logic [7:0] n, input int want);
        addrQ.delete();
        irqCnt = 0;
        nullCnt = 0;
        @(posedge ref_clk);
        burst <= n;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        for (int i = 0; i < 400 && (addrQ.size() < want || i < 40); i++)
            @(posedge ref_clk);
        #1;
    endtask : run
    task automatic qchk(input int from, input logic [15:0] base,
                        input logic [15:0] step, input int n);
        for (int i = 0; i < n; i++)
            check("ram address", addrQ[from + i][15:0], base + step * 16'(i));
    endtask : qchk
    task automatic collide(input logic [15:0] ctl, input logic [15:0] flag);
        logic [15:0] dirExp;
        dirExp = ctl[13] ? 16'h0001 : 16'h0002;
        wr(OFF_CONTROL, 16'h0000);
        wr(OFF_START_A, 16'h0600);
        wr(OFF_PERIPH, 16'h0040);
        wr(OFF_CONTROL, ctl);
        cpuRamWr <= 1'b1;
        cpuRamAddr <= 16'h0600;
        cpuPerWr <= 1'b1;
        cpuPerAddr <= 16'h0040;
        run(8'h01, 1);
        check("ram dir", {14'h0, addrQ[0][17:16]}, dirExp);
        check("periph dir", {14'h0, perSeen[17:16]}, dirExp);
        check("periph address", perSeen[15:0], 16'h0040);
        cpuRamWr <= 1'b0;
        cpuPerWr <= 1'b0;
        check("trap", {15'h0, trap}, 16'h0001);
        check("trap level", {12'h0, trapLevel}, 16'h000a);
        rc(OFF_COLLISION, flag, "collision flags");
        wr(OFF_COLLISION, 16'h0000);
        rc(OFF_COLLISION, 16'h0000, "flags cleared");
        #1 check("trap released", {15'h0, trap}, 16'h0000);
    endtask : collide
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // ==========================================================
    // clock, watchdog and test sequence
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        bus = '0;
        {cpuRamWr, cpuPerWr} = 2'b00;
        {cpuRamAddr, cpuPerAddr} = 32'h0;
        srcSel = 7'h0d;
        burst = 8'h00;
        go = 1'b0;
        perOffset = 16'h0000;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a <= 32; a += 4)
            rc(8'(a), RESET_VAL, "reset or hole");
        $display("test reset done");
        wr(OFF_REQUEST, 16'h000d);
        wr(OFF_START_A, 16'h0100);
        wr(OFF_COUNT, 16'h0003);
        wr(OFF_CONTROL, 16'h8000);
        run(8'h04, 4);
        check("block length", 16'(addrQ.size()), 16'h0004);
        qchk(0, 16'h0100, 16'h0002, 4);
        check("to ram", {14'h0, addrQ[0][17:16]}, 16'h0002);
        check("full irqs", 16'(irqCnt), 16'h0001);
        rc(OFF_CONTROL, 16'h8000, "stays enabled");
        rc(OFF_START_A, 16'h0100, "reload address");
        run(8'h01, 1);
        qchk(0, 16'h0100, 16'h0002, 1);
        $display("test continuous done");
        wr(OFF_CONTROL, 16'h0000);
        wr(OFF_START_A, 16'h0201);
        wr(OFF_COUNT, 16'h0001);
        wr(OFF_CONTROL, 16'hc801);
        run(8'h03, 2);
        check("one-shot length", 16'(addrQ.size()), 16'h0002);
        qchk(0, 16'h0201, 16'h0001, 2);
        check("null writes", 16'(nullCnt), 16'h0002);
        check("one-shot irqs", 16'(irqCnt), 16'h0001);
        rc(OFF_CONTROL, 16'h4801, "self disabled");
        rc(OFF_START_A, 16'h0202, "last address kept");
        $display("test one-shot done");
        wr(OFF_CONTROL, 16'h0000);
        wr(OFF_START_A, 16'h0300);
        wr(OFF_START_B, 16'h0400);
        wr(OFF_COUNT, 16'h0003);
        wr(OFF_CONTROL, 16'h9002);
        run(8'h08, 8);
        qchk(0, 16'h0300, 16'h0002, 4);
        qchk(4, 16'h0400, 16'h0002, 4);
        check("half irqs", 16'(irqCnt), 16'h0002);
        $display("test ping-pong done");
        wr(OFF_CONTROL, 16'h0000);
        wr(OFF_START_A, 16'h0500);
        wr(OFF_CONTROL, 16'h8000);
        wr(OFF_REQUEST, 16'h800d);
        wr(OFF_REQUEST, 16'h800d);
        run(8'h00, 1);
        check("forced length", 16'(addrQ.size()), 16'h0001);
        qchk(0, 16'h0500, 16'h0002, 1);
        rc(OFF_REQUEST, 16'h000d, "force cleared");
        run(8'h01, 1);
        qchk(0, 16'h0502, 16'h0002, 1);
        srcSel <= 7'h0e;
        run(8'h01, 0);
        check("other line", 16'(addrQ.size()), 16'h0000);
        srcSel <= 7'h0d;
        $display("test force done");
        wr(OFF_CONTROL, 16'h0000);
        wr(OFF_START_A, 16'h0700);
        wr(OFF_COUNT, 16'h0001);
        wr(OFF_CONTROL, 16'h8010);
        run(8'h02, 2);
        qchk(0, 16'h0700, 16'h0000, 2);
        wr(OFF_CONTROL, 16'h0000);
        perOffset <= 16'h0006;
        wr(OFF_CONTROL, 16'h8020);
        run(8'h01, 1);
        qchk(0, 16'h0706, 16'h0000, 1);
        perOffset <= 16'h0000;
        $display("test addressing done");
        collide(16'h8000, 16'h0001);
        collide(16'ha000, 16'h0002);
        $display("test collision done");
        close_out();
    end
endmodule : tb_top
